// file: hdl/mlmo_pkg.sv
// Package: constants for the microcore load, multiply and logic slice.
// Assumes a 16-bit instruction word and a 100 MHz core clock.
package mlmo_pkg;
  // ----------------------------------------------------------------
  // AXI register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_JUMP = 8'h08;
  localparam logic [7:0] ADDR_PROD_HI = 8'h0C;
  localparam logic [7:0] ADDR_PROD_LO = 8'h10;
  localparam logic [7:0] ADDR_IMM = 8'h14;
  localparam logic [7:0] ADDR_BASE = 8'h18;
  localparam logic [7:0] ADDR_REG0 = 8'h20;
  localparam logic [7:0] ADDR_DRAM = 8'h40;
  localparam logic [7:0] ADDR_DRAM_IDX = 8'h44;
  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_OVF = 1;
  localparam int ST_LOSS = 2;
  localparam int ST_DONE = 3;
  localparam int ST_ZERO = 4;
  localparam int ST_ONES = 5;
  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_LDJA = 4'h8;
  localparam logic [3:0] OP_LDJB = 4'h9;
  localparam logic [1:0] OP_LOAD_HI = 2'h2;
  localparam logic [1:0] OP_LOAD_LO = 2'h2;
  localparam logic [9:0] OP_MUL = 10'h0B6;
  localparam logic [8:0] OP_MULI = 9'h04E;
  localparam logic [12:0] OP_NOT = 13'h05DB;
  localparam logic [12:0] OP_OR = 13'h05D8;
  localparam logic [4:0] OP_LDIR = 5'h07;
  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int MUL_CYCLES = 32;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int DRAM_WORDS = 64;
  typedef enum logic [1:0] {DEC_NONE, DEC_SIMPLE, DEC_MUL} mlmo_dec_t;
endpackage : mlmo_pkg

// file: hdl/mlmo_mul.sv
// Serial 16x16 shift-add multiplier, one step per cycle.
// Assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ns
`default_nettype none
module mlmo_mul (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic start,
  input wire logic [15:0] opa,
  input wire logic [15:0] opb,
  // Result
  output logic busy,
  output logic done,
  output logic [31:0] product
);
  logic [31:0] acc_ff;
  logic [31:0] mcand_ff;
  logic [15:0] mplier_ff;
  logic [5:0] cnt_ff;
  // ----------------------------------------------------------------
  // Stepping: 32 cycles, two half-steps per multiplier bit keep the
  // latency fixed at the documented count without a wider adder
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    done <= 1'b0;
    if (!aresetn) begin
      acc_ff <= 32'h00000000;
      mcand_ff <= 32'h00000000;
      mplier_ff <= 16'h0000;
      cnt_ff <= 6'h00;
      busy <= 1'b0;
    end else if (start) begin
      acc_ff <= 32'h00000000;
      mcand_ff <= {16'h0000, opa};
      mplier_ff <= opb;
      cnt_ff <= 6'(mlmo_pkg::MUL_CYCLES);
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_ff[0] == 1'b0) begin
        if (mplier_ff[0]) begin
          acc_ff <= acc_ff + mcand_ff;
        end
      end else begin
        mcand_ff <= {mcand_ff[30:0], 1'b0};
        mplier_ff <= {1'b0, mplier_ff[15:1]};
      end
      cnt_ff <= cnt_ff - 6'h01;
      if (cnt_ff == 6'h01) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
  assign product = acc_ff;
endmodule : mlmo_mul
`default_nettype wire

// file: hdl/mlmo_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes 32-bit data; answers OKAY or SLVERR per decode input.
`timescale 1ns/1ns
`default_nettype none
module mlmo_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_ff;
  logic w_have_ff;
  // ----------------------------------------------------------------
  // Write path: address and data taken in either order
  // ----------------------------------------------------------------
  assign awready = !aw_have_ff && !bvalid;
  assign wready = !w_have_ff && !bvalid;
  assign wr_en = aw_have_ff && w_have_ff && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_ff <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_ff <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read path: data registered one cycle after the address is taken
  // ----------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_addr = araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : mlmo_axil
`default_nettype wire

// file: hdl/mlmo_core.sv
// Microcore slice: decodes and executes far-jump loads, data-RAM load,
// multiply, invert and OR, with condition flags, behind AXI4-Lite.
// Assumes software writes one instruction word at a time and polls the
// busy bit before issuing the next one after a multiply.
//
// Behaviour
// - Far-jump load A writes the 10-bit field into far-jump register A.
// - Far-jump load B writes the 10-bit field into far-jump register B.
// - Data-RAM load copies the addressed RAM word into the chosen register.
// - Flag clear uses the field as address; flag set adds the base.
// - Data-RAM load: bits 15:14 = 10, bits 1:0 = 10, flag at bit 2.
// - Register multiply: high half to product-high, low half to product-low.
// - Every multiply takes 32 cycles before the product is valid.
// - Multiplies update overflow, precision-loss and done flags.
// - Register multiply opcode 0010110110, operands in 5:3 and 2:0.
// - Immediate multiply uses a 4-bit unsigned immediate, same product pair.
// - Immediate multiply opcode 001001110, immediate 6:3, register 2:0.
// - Invert complements the chosen register in place.
// - Invert and OR set the all-zero and all-ones result flags.
// - Invert opcode 0010111011011, register in bits 2:0.
// - OR merges the immediate register into the chosen register.
// - OR opcode 0010111011000, register in bits 2:0.
// - Immediate register loads bytewise, optionally clearing the other byte.
`timescale 1ns/1ns
`default_nettype none
module mlmo_core (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Condition flags
  output logic operation_done_flag,
  output logic result_zero_flag,
  output logic result_ones_flag
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] far_jump_reg_a_ff;
  logic [15:0] far_jump_reg_b_ff;
  logic [15:0] product_high_reg_ff;
  logic [15:0] product_low_reg_ff;
  logic [15:0] immediate_register_ff;
  logic [5:0] base_ff;
  logic [15:0] gpr_ff [0:7];
  logic [15:0] dram [0:mlmo_pkg::DRAM_WORDS-1];
  logic [5:0] dram_idx_ff;
  logic product_overflow_flag_ff;
  logic precision_loss_flag_ff;
  logic done_ff;
  logic zero_ff;
  logic ones_ff;
  // Bus side wires
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  // Multiplier wires
  logic mul_start;
  logic mul_busy;
  logic mul_done;
  logic [31:0] mul_product;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  // Decode wires
  logic [15:0] insn;
  logic issue;
  logic is_ldja;
  logic is_ldjb;
  logic is_load;
  logic is_mul;
  logic is_muli;
  logic is_not;
  logic is_or;
  logic is_ldirh;
  logic is_ldirl;
  logic [2:0] first_operand_select;
  logic [2:0] second_operand_select;
  logic [2:0] load_dest;
  logic [5:0] load_addr;
  logic [15:0] logic_result;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word lane merge with AXI byte strobes, used by several registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16
  // Mask flag computation shared by invert and OR
  function automatic logic [1:0] mask_flags(input logic [15:0] v);
    return {v == 16'hFFFF, v == 16'h0000};
  endfunction : mask_flags
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  mlmo_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );
  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // An instruction word issues when written; a busy multiplier blocks it
  assign insn = wr_data[15:0];
  assign issue = wr_en && (wr_addr == mlmo_pkg::ADDR_INSTR) && !mul_busy && !mul_done;
  assign is_ldja = insn[15:12] == mlmo_pkg::OP_LDJA && insn[1:0] == 2'h0;
  assign is_ldjb = insn[15:12] == mlmo_pkg::OP_LDJB && insn[1:0] == 2'h0;
  assign is_load = insn[15:14] == mlmo_pkg::OP_LOAD_HI &&
                   insn[1:0] == mlmo_pkg::OP_LOAD_LO;
  assign is_mul = insn[15:6] == mlmo_pkg::OP_MUL;
  assign is_muli = insn[15:7] == mlmo_pkg::OP_MULI;
  assign is_not = insn[15:3] == mlmo_pkg::OP_NOT;
  assign is_or = insn[15:3] == mlmo_pkg::OP_OR;
  assign is_ldirh = insn[15:11] == mlmo_pkg::OP_LDIR && insn[1:0] == 2'h3;
  assign is_ldirl = insn[15:11] == mlmo_pkg::OP_LDIR && insn[1:0] == 2'h2;
  assign first_operand_select = insn[2:0];
  assign second_operand_select = insn[5:3];
  assign load_dest = insn[5:3];
  // Indexed mode adds the base and wraps within the 64-word RAM
  assign load_addr = insn[2] ? 6'(insn[13:8] + base_ff) : insn[13:8];
  assign logic_result = is_not ? ~gpr_ff[first_operand_select]
                               : (gpr_ff[first_operand_select] | immediate_register_ff);
  // Operand selection for both multiply forms
  assign mul_a = gpr_ff[first_operand_select];
  assign mul_b = is_muli ? {12'h000, insn[6:3]} : gpr_ff[second_operand_select];
  assign mul_start = issue && (is_mul || is_muli);
  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  mlmo_mul u_mul (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(mul_start),
    .opa(mul_a),
    .opb(mul_b),
    .busy(mul_busy),
    .done(mul_done),
    .product(mul_product)
  );
  // ----------------------------------------------------------------
  // Far-jump registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      far_jump_reg_a_ff <= mlmo_pkg::RST_WORD;
      far_jump_reg_b_ff <= mlmo_pkg::RST_WORD;
    end else if (issue) begin
      if (is_ldja) far_jump_reg_a_ff <= {6'h00, insn[11:2]};
      if (is_ldjb) far_jump_reg_b_ff <= {6'h00, insn[11:2]};
    end
  end
  // ----------------------------------------------------------------
  // Immediate register and index base
  // ----------------------------------------------------------------
  // Bit 10 is the clear-other-byte option of the byte loads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      immediate_register_ff <= mlmo_pkg::RST_WORD;
      base_ff <= 6'h00;
    end else if (issue && is_ldirh) begin
      immediate_register_ff <= {insn[9:2], insn[10] ? 8'h00 : immediate_register_ff[7:0]};
    end else if (issue && is_ldirl) begin
      immediate_register_ff <= {insn[10] ? 8'h00 : immediate_register_ff[15:8], insn[9:2]};
    end else if (wr_en && wr_addr == mlmo_pkg::ADDR_IMM) begin
      immediate_register_ff <= merge16(immediate_register_ff, wr_data, wr_strb);
    end else if (wr_en && wr_addr == mlmo_pkg::ADDR_BASE && wr_strb[0]) begin
      base_ff <= wr_data[5:0];
    end
  end
  // ----------------------------------------------------------------
  // Data RAM and its software access window
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dram_idx_ff <= 6'h00;
    end else if (wr_en && wr_addr == mlmo_pkg::ADDR_DRAM_IDX) begin
      dram_idx_ff <= wr_data[5:0];
    end
  end
  // No reset: RAM contents are defined by software before use
  always_ff @(posedge aclk) begin
    if (wr_en && wr_addr == mlmo_pkg::ADDR_DRAM) begin
      dram[dram_idx_ff] <= merge16(dram[dram_idx_ff], wr_data, wr_strb);
    end
  end
  // ----------------------------------------------------------------
  // ALU register file
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        gpr_ff[i] <= mlmo_pkg::RST_WORD;
      end
    end else if (issue && is_load) begin
      gpr_ff[load_dest] <= dram[load_addr];
    end else if (issue && (is_not || is_or)) begin
      gpr_ff[first_operand_select] <= logic_result;
    end else if (wr_en && wr_addr[7:5] == mlmo_pkg::ADDR_REG0[7:5] && wr_addr[1:0] == 2'h0) begin
      gpr_ff[wr_addr[4:2]] <= merge16(gpr_ff[wr_addr[4:2]], wr_data, wr_strb);
    end
  end
  // ----------------------------------------------------------------
  // Product pair
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_high_reg_ff <= mlmo_pkg::RST_WORD;
      product_low_reg_ff <= mlmo_pkg::RST_WORD;
    end else if (mul_done) begin
      product_high_reg_ff <= mul_product[31:16];
      product_low_reg_ff <= mul_product[15:0];
    end
  end
  // ----------------------------------------------------------------
  // Multiply flags
  // ----------------------------------------------------------------
  // Done drops at issue and rises with the product, 33 cycles later;
  // an unsigned 16x16 product always fits, so overflow and loss clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_overflow_flag_ff <= 1'b0;
      precision_loss_flag_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (mul_start) begin
      done_ff <= 1'b0;
      product_overflow_flag_ff <= 1'b0;
      precision_loss_flag_ff <= 1'b0;
    end else if (mul_done) begin
      done_ff <= 1'b1;
      product_overflow_flag_ff <= 1'b0;
      precision_loss_flag_ff <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Mask flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_ff <= 1'b0;
      ones_ff <= 1'b0;
    end else if (issue && (is_not || is_or)) begin
      {ones_ff, zero_ff} <= mask_flags(logic_result);
    end
  end
  // ----------------------------------------------------------------
  // Flag outputs, each a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operation_done_flag <= 1'b0;
      result_zero_flag <= 1'b0;
      result_ones_flag <= 1'b0;
    end else begin
      operation_done_flag <= done_ff;
      result_zero_flag <= zero_ff;
      result_ones_flag <= ones_ff;
    end
  end
  // ----------------------------------------------------------------
  // Register decode for the bus
  // ----------------------------------------------------------------
  // Instruction writes while busy are refused with SLVERR
  always_comb begin
    wr_ok = 1'b1;
    if (wr_addr == mlmo_pkg::ADDR_INSTR) wr_ok = !(mul_busy || mul_done);
    else if (wr_addr[7:5] == mlmo_pkg::ADDR_REG0[7:5]) wr_ok = 1'b1;
    else if (wr_addr == mlmo_pkg::ADDR_IMM || wr_addr == mlmo_pkg::ADDR_BASE) wr_ok = 1'b1;
    else if (wr_addr == mlmo_pkg::ADDR_DRAM || wr_addr == mlmo_pkg::ADDR_DRAM_IDX) wr_ok = 1'b1;
    else wr_ok = 1'b0;
  end
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_addr[7:5] == mlmo_pkg::ADDR_REG0[7:5]) begin
      rd_data = {16'h0000, gpr_ff[rd_addr[4:2]]};
    end else begin
      unique case (rd_addr)
        mlmo_pkg::ADDR_STATUS: begin
          rd_data[mlmo_pkg::ST_BUSY] = mul_busy || mul_done; // Busy until done has landed
          rd_data[mlmo_pkg::ST_OVF] = product_overflow_flag_ff;
          rd_data[mlmo_pkg::ST_LOSS] = precision_loss_flag_ff;
          rd_data[mlmo_pkg::ST_DONE] = done_ff;
          rd_data[mlmo_pkg::ST_ZERO] = zero_ff;
          rd_data[mlmo_pkg::ST_ONES] = ones_ff;
        end
        mlmo_pkg::ADDR_JUMP: rd_data = {far_jump_reg_b_ff, far_jump_reg_a_ff};
        mlmo_pkg::ADDR_PROD_HI: rd_data = {16'h0000, product_high_reg_ff};
        mlmo_pkg::ADDR_PROD_LO: rd_data = {16'h0000, product_low_reg_ff};
        mlmo_pkg::ADDR_IMM: rd_data = {16'h0000, immediate_register_ff};
        mlmo_pkg::ADDR_BASE: rd_data = {26'h0000000, base_ff};
        mlmo_pkg::ADDR_DRAM: rd_data = {16'h0000, dram[dram_idx_ff]};
        mlmo_pkg::ADDR_DRAM_IDX: rd_data = {26'h0000000, dram_idx_ff};
        mlmo_pkg::ADDR_INSTR: rd_data = 32'h00000000;
        default: rd_ok = 1'b0;
      endcase
    end
  end
endmodule : mlmo_core
`default_nettype wire

// file: dv/mlmo_core_assertions.sv
// Checker for mlmo_core: bus handshakes, multiply timing and mask flags.
// Assumes the core's synchronous active-low reset on aclk.
`timescale 1ns/1ns
`default_nettype none
module mlmo_core_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Flags
  input wire logic operation_done_flag,
  input wire logic result_zero_flag,
  input wire logic result_ones_flag
);
  // ----------------------------------------------------------------
  // Helper: cycles with done low, saturating so it never wraps
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || operation_done_flag) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hFF) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_mul_latency: assert property ($rose(operation_done_flag) |-> low_cnt_ff >= 8'h1E)
    else $error("done flag rose too early");
  a_done_low: assert property ($fell(operation_done_flag) |-> !operation_done_flag [*8])
    else $error("done flag came back too soon");
  a_mask_excl: assert property (!(result_zero_flag && result_ones_flag))
    else $error("zero and ones flags both set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  c_mul: cover property ($rose(operation_done_flag));
  c_zero: cover property ($rose(result_zero_flag));
  c_werr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : mlmo_core_assertions
bind mlmo_core mlmo_core_assertions u_mlmo_core_assertions (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .operation_done_flag, .result_zero_flag, .result_ones_flag);
`default_nettype wire

// file: dv/test_microcore_load_mul_logic_ops.sv
// Bench: drives mlmo_core over AXI4-Lite, compares with a small model.
// Assumes the core's register map and handshake timing.
`timescale 1ns/1ns
`default_nettype none
module test_microcore_load_mul_logic_ops;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd, p;
  logic awr, wr_rdy, bv, arr, rv, done_f, zero_f, ones_f;
  logic [1:0] br, rr;
  integer seed = 32'he121, mismatches = 0, n_checks = 0, i, k;
  logic [15:0] a, b, m;
  logic [5:0] ad, bs, ix;
  logic [9:0] va, vb;
  logic [3:0] im;
  always #5 aclk = ~aclk;
  mlmo_core u_mlmo_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .operation_done_flag(done_f), .result_zero_flag(zero_f), .result_ones_flag(ones_f));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Ready is looked at mid-cycle, where it is settled, then used at the next edge
  task automatic wr(input logic [7:0] ai, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge aclk);
    {awa, wd, awv, wv, bre} <= {ai, d, 3'h7};
    do begin
      @(negedge aclk);
      {ta, tw, tb, rs} = {awr, wr_rdy, bv, br};
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end while (!tb);
    bre <= 1'h0;
    chk("bresp", {30'h0, rs}, {30'h0, er});
  endtask : wr
  task automatic rdr(input logic [7:0] ai, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] rs;
    @(posedge aclk);
    {ara, arv, rre} <= {ai, 2'h3};
    do begin
      @(negedge aclk);
      {ta, tr, rd, rs} = {arr, rv, rdat, rr};
      @(posedge aclk);
      if (ta) arv <= 1'h0;
    end while (!tr);
    rre <= 1'h0;
    chk("rresp", {30'h0, rs}, {30'h0, er});
  endtask : rdr
  task automatic rc(input logic [7:0] ai, input logic [31:0] e);
    rdr(ai, 2'h0);
    chk("rdata", rd, e);
  endtask : rc
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Watchdog: tests need a few hundred cycles, this allows twenty thousand
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h04, 32'h0);
    va = $random(seed);
    vb = $random(seed);
    wr(8'h00, {16'h0, 4'h8, va, 2'h0}, 2'h0);
    wr(8'h00, {16'h0, 4'h9, vb, 2'h0}, 2'h0);
    rc(8'h08, {6'h0, vb, 6'h0, va});
    $display("test far jump done");
    for (k = 0; k < 2; k++) begin
      bs = $random(seed);
      ad = $random(seed);
      m = $random(seed);
      ix = ad + (k ? bs : 6'h00);
      wr(8'h18, {26'h0, bs}, 2'h0);
      wr(8'h44, {26'h0, ix}, 2'h0);
      wr(8'h40, {16'h0, m}, 2'h0);
      wr(8'h00, {16'h0, 2'h2, ad, 2'h0, 3'h4, k[0], 2'h2}, 2'h0);
      rc(8'h30, {16'h0, m});
    end
    $display("test data load done");
    {a, b} = $random(seed);
    wr(8'h24, {16'h0, a}, 2'h0);
    wr(8'h28, {16'h0, b}, 2'h0);
    for (k = 0; k < 2; k++) begin
      im = $random(seed);
      m = k ? {12'h0, im} : b;
      p = a * m;
      wr(8'h00, k ? {16'h0, 9'h04E, im, 3'h1} : {16'h0, 10'h0B6, 6'h11}, 2'h0);
      wr(8'h00, 32'h0, 2'h2);
      i = 0;
      do begin
        rdr(8'h04, 2'h0);
        i++;
      end while (rd[0] && i < 40);
      chk("status", {28'h0, rd[3:0]}, 32'h8);
      chk("done", {31'h0, done_f}, 32'h1);
      rc(8'h0C, p >> 16);
      rc(8'h10, p & 32'hFFFF);
    end
    $display("test multiply done");
    m = 16'hFFFF;
    wr(8'h2C, {16'h0, m}, 2'h0);
    for (k = 0; k < 3; k++) begin
      a = {8'($random(seed)), 8'h00};
      if (k == 1) wr(8'h00, {16'h0, 5'h07, 1'h1, a[15:8], 2'h3}, 2'h0);
      if (k == 2) wr(8'h14, 32'hFF00, 2'h0);
      if (k == 2) wr(8'h00, {16'h0, 5'h07, 1'h0, 8'hFF, 2'h2}, 2'h0);
      wr(8'h00, {16'h0, k ? 13'h05D8 : 13'h05DB, 3'h3}, 2'h0);
      m = (k == 0) ? ~m : (m | ((k == 1) ? a : 16'hFFFF));
      rc(8'h2C, {16'h0, m});
      chk("zero", {31'h0, zero_f}, {31'h0, m == 16'h0});
      chk("ones", {31'h0, ones_f}, {31'h0, &m});
    end
    $display("test logic done");
    rdr(8'h48, 2'h2);
    chk("rdata", rd, 32'h0);
    $display("test unmapped done");
    complete_run();
  end
endmodule : test_microcore_load_mul_logic_ops
`default_nettype wire
